// file: design/usbsie_regs.sv
// Operation
// - The pull switch bit set connects the D+ pull resistor to the bus supply line, clear disconnects it.
// - A read-only bit shows 1 while the interface sits in J-state suspend, else 0.
// - The current-cut bit set reduces supply current while suspended; clear applies no reduction.
// - The two-bit FIFO select steers CPU FIFO access to endpoint 0, 1, 2 or 3.
// - The address register resets to zero, address zero with wake-up disabled.
// - The upper seven address bits hold the device address and tokens to it are answered.
// - Address bit 0 is a read/write remote wake-up enable.
// - A status control bit decides whether a new address applies at once or later.
// - With that bit 0 the address applies on write; with 1 only after IN data are fully read.
// - Four read/write stall flags, one per endpoint, make that endpoint answer with a stall.
// - Every stall flag clears on a bus reset and on a setup token.
// - Stall register bits 7 to 4 ignore writes and read as zero.
`timescale 1ns/10ps
module usbsie_regs
	import usbsie_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [APB_AW-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic                   pready,
	output logic [DATA_W-1:0]      prdata,
	output logic                   pslverr,
	input  wire logic              jstate_line,
	input  wire logic              sie_suspend,
	input  wire logic              usb_bus_reset,
	input  wire logic              setup_token,
	input  wire logic              in_data_read_done,
	input  wire logic              token_valid,
	input  wire logic [ADDR_W-1:0] token_addr,
	input  wire logic [FSEL_W-1:0] token_ep,
	output logic                   dplus_pull_resistor_en,
	output logic                   suspend_current_cut_en,
	output logic                   usb_clock_gate_en,
	output logic [FSEL_W-1:0]      fifo_select,
	output logic [NUM_EP-1:0]      ep_fifo_sel,
	output logic [ADDR_W-1:0]      device_addr_field,
	output logic                   remote_wake_enable,
	output logic [NUM_EP-1:0]      ep_halt_flags,
	output logic                   addr_match,
	output logic                   stall_reply
);
	typedef struct packed {
		logic              pull;
		logic              cut;
		logic              cut_on;
		logic              clkg;
		logic [FSEL_W-1:0] fsel;
		logic [ADDR_W-1:0] addr;
		logic              wake;
		logic [ADDR_W-1:0] active;
		logic              pending;
		logic              defer;
		logic [NUM_EP-1:0] stall;
		logic [DATA_W-1:0] rdata;
	} usbsie_regs_s;

	usbsie_regs_s st_ff;
	usbsie_regs_s nxt_st;
	logic         jstate_sync;
	logic         setup_ph;
	logic         access_ph;
	logic         addr_hit;
	logic         wr_ctrl;
	logic         wr_addr;
	logic         wr_stall;
	logic         wr_status;
	logic         rd_ctrl;
	logic         rd_stall;

	// Suspend line comes straight off the transceiver, so it is caught first
	usbsie_sync u_jstate_sync (
		.pclk      (pclk),
		.presetn   (presetn),
		.async_in  (jstate_line),
		.level_out (jstate_sync)
	);

	// APB decode; zero wait states, so pready stays high
	assign setup_ph  = psel && !penable;
	assign access_ph = psel && penable;
	assign addr_hit  = (paddr == OFS_CTRL_CONFIG) || (paddr == OFS_ADDR_WAKE) ||
	                   (paddr == OFS_STALL) || (paddr == OFS_ADDR_STATUS);
	assign wr_ctrl   = access_ph && pwrite && (paddr == OFS_CTRL_CONFIG);
	assign wr_addr   = access_ph && pwrite && (paddr == OFS_ADDR_WAKE);
	assign wr_stall  = access_ph && pwrite && (paddr == OFS_STALL);
	assign wr_status = access_ph && pwrite && (paddr == OFS_ADDR_STATUS);
	assign rd_ctrl   = setup_ph && !pwrite && (paddr == OFS_CTRL_CONFIG);
	assign rd_stall  = setup_ph && !pwrite && (paddr == OFS_STALL);
	assign pready    = 1'h1;
	assign pslverr   = access_ph && !addr_hit; // Unmapped words answer with an error

	// Next-state logic for every register and the read capture
	always_comb begin
		nxt_st = st_ff;
		if (wr_ctrl) begin
			nxt_st.pull = pwdata[CC_PULL_BIT];
			nxt_st.cut  = pwdata[CC_CUT_BIT];
			nxt_st.clkg = pwdata[CC_CLKG_BIT];
			nxt_st.fsel = pwdata[CC_FSEL_LSB +: FSEL_W];
		end
		// reduction only while actually suspended
		// Built from the stored bit, so the cut lags a write by one cycle
		nxt_st.cut_on = st_ff.cut && sie_suspend;
		if (wr_addr) begin
			nxt_st.addr = pwdata[AW_ADDR_LSB +: ADDR_W];
			nxt_st.wake = pwdata[AW_WAKE_BIT];
		end
		if (wr_status) begin
			nxt_st.defer = pwdata[AS_DEFER_BIT];
		end
		// immediate path takes the written value on the same edge
		if (wr_addr && !st_ff.defer) begin
			nxt_st.active  = pwdata[AW_ADDR_LSB +: ADDR_W];
			nxt_st.pending = AS_PEND_RST;
		end else if (!st_ff.defer || (st_ff.pending && in_data_read_done)) begin
			nxt_st.active  = st_ff.addr;
			nxt_st.pending = AS_PEND_RST;
		end
		// a deferred write waits; a new write beats a same-cycle drain
		if (wr_addr && st_ff.defer) begin
			nxt_st.pending = 1'h1;
		end
		if (wr_stall) begin
			// software sets or clears stall flags
			nxt_st.stall = pwdata[NUM_EP-1:0];
		end
		// hardware clear outranks a software write in the same cycle
		if (usb_bus_reset || setup_token) begin
			nxt_st.stall = STALL_RST;
		end
		// Read data captured in the setup phase, so prdata is a flop
		if (setup_ph && !pwrite) begin
			nxt_st.rdata = '0;
			unique case (paddr)
				OFS_CTRL_CONFIG: begin
					// gaps at bits 6 and 2 stay zero
					nxt_st.rdata[CC_PULL_BIT]               = st_ff.pull;
					nxt_st.rdata[CC_JSTATE_BIT]             = jstate_sync;
					nxt_st.rdata[CC_CUT_BIT]                = st_ff.cut;
					nxt_st.rdata[CC_CLKG_BIT]               = st_ff.clkg;
					nxt_st.rdata[CC_FSEL_LSB +: FSEL_W]     = st_ff.fsel;
				end
				OFS_ADDR_WAKE: begin
					nxt_st.rdata[AW_ADDR_LSB +: ADDR_W]     = st_ff.addr;
					nxt_st.rdata[AW_WAKE_BIT]               = st_ff.wake;
				end
				OFS_STALL: begin
					// only the low four bits exist
					nxt_st.rdata[NUM_EP-1:0]                = st_ff.stall;
				end
				OFS_ADDR_STATUS: begin
					nxt_st.rdata[AS_DEFER_BIT]              = st_ff.defer;
					nxt_st.rdata[AS_ACTIVE_LSB +: ADDR_W]   = st_ff.active;
				end
				default: begin
					nxt_st.rdata = '0;
				end
			endcase
		end
	end

	// address register and everything else start from zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff.pull    <= CC_PULL_RST;
			st_ff.cut     <= CC_CUT_RST;
			st_ff.cut_on  <= CC_CUT_RST;
			st_ff.clkg    <= CC_CLKG_RST;
			st_ff.fsel    <= CC_FSEL_RST;
			st_ff.addr    <= AW_ADDR_RST;
			st_ff.wake    <= AW_WAKE_RST;
			st_ff.active  <= AW_ADDR_RST;
			st_ff.pending <= AS_PEND_RST;
			st_ff.defer   <= AS_DEFER_RST;
			st_ff.stall   <= STALL_RST;
			st_ff.rdata   <= RDATA_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from the state flops
	assign prdata                 = st_ff.rdata;
	assign dplus_pull_resistor_en = st_ff.pull;
	assign suspend_current_cut_en = st_ff.cut_on;
	assign usb_clock_gate_en      = st_ff.clkg;
	assign fifo_select            = st_ff.fsel;
	assign device_addr_field      = st_ff.active;
	assign remote_wake_enable     = st_ff.wake;
	assign ep_halt_flags          = st_ff.stall;

	genvar g;
	generate
		for (g = 0; g < NUM_EP; g++) begin : g_fsel
			assign ep_fifo_sel[g] = (st_ff.fsel == FSEL_W'(g));
		end
	endgenerate

	// answer only tokens for the address in force
	assign addr_match  = token_valid && (token_addr == st_ff.active);
	// stalled endpoint answers with a stall handshake
	assign stall_reply = addr_match && st_ff.stall[token_ep];

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	pull_switch_a: assert property (wr_ctrl |=> dplus_pull_resistor_en == $past(pwdata[CC_PULL_BIT]))
		else $error("pull switch did not follow write");
	jstate_read_a: assert property (rd_ctrl |=> prdata[CC_JSTATE_BIT] == $past(jstate_sync))
		else $error("suspend status read wrong");
	current_cut_a: assert property (suspend_current_cut_en |-> $past(st_ff.cut && sie_suspend))
		else $error("current cut without cause");
	clock_gate_a: assert property (wr_ctrl |=> usb_clock_gate_en == $past(pwdata[CC_CLKG_BIT]))
		else $error("clock gate did not follow write");
	fifo_onehot_a: assert property ($onehot(ep_fifo_sel) && ep_fifo_sel[fifo_select])
		else $error("fifo select not one-hot");
	ctrl_gaps_a: assert property (rd_ctrl |=> !prdata[CC_GAP6_BIT] && !prdata[CC_GAP2_BIT] &&
		prdata[DATA_W-1:REG_W] == '0)
		else $error("control gap bits not zero");
	wake_store_a: assert property (wr_addr |=> remote_wake_enable == $past(pwdata[AW_WAKE_BIT]))
		else $error("wake enable not stored");
	addr_now_a: assert property (wr_addr && !st_ff.defer |=>
		device_addr_field == $past(pwdata[AW_ADDR_LSB +: ADDR_W]))
		else $error("immediate address not applied");
	addr_hold_a: assert property (st_ff.defer && st_ff.pending && !in_data_read_done && !wr_status |=>
		$stable(device_addr_field))
		else $error("deferred address applied early");
	addr_drain_a: assert property (st_ff.pending && in_data_read_done && !(wr_addr && !st_ff.defer) |=>
		device_addr_field == $past(st_ff.addr))
		else $error("deferred address not applied");
	stall_reply_a: assert property (token_valid && token_addr == device_addr_field &&
		ep_halt_flags[token_ep] |-> stall_reply)
		else $error("stalled endpoint did not stall");
	stall_clear_a: assert property (usb_bus_reset || setup_token |=> ep_halt_flags == '0)
		else $error("stall flags not cleared");
	stall_upper_a: assert property (rd_stall |=> prdata[DATA_W-1:NUM_EP] == '0)
		else $error("stall upper bits not zero");
endmodule

// file: inc/usbsie_pkg.sv
package usbsie_pkg;
	// Bus geometry
	localparam int APB_AW   = 8;
	localparam int DATA_W   = 32;
	localparam int REG_W    = 8;
	localparam int NUM_EP   = 4;
	localparam int ADDR_W   = 7;
	localparam int FSEL_W   = 2;

	// Register byte offsets, one aligned word each
	localparam logic [APB_AW-1:0] OFS_CTRL_CONFIG = 8'h00;
	localparam logic [APB_AW-1:0] OFS_ADDR_WAKE   = 8'h04;
	localparam logic [APB_AW-1:0] OFS_STALL       = 8'h08;
	localparam logic [APB_AW-1:0] OFS_ADDR_STATUS = 8'h0c;

	// usb_control_config fields
	localparam int CC_PULL_BIT  = 7;
	localparam int CC_GAP6_BIT  = 6;
	localparam int CC_JSTATE_BIT = 5;
	localparam int CC_CUT_BIT   = 4;
	localparam int CC_CLKG_BIT  = 3;
	localparam int CC_GAP2_BIT  = 2;
	localparam int CC_FSEL_LSB  = 0;

	// device_address_wake fields
	localparam int AW_WAKE_BIT = 0;
	localparam int AW_ADDR_LSB = 1;

	// Address status fields (deferred control and address in force)
	localparam int AS_DEFER_BIT  = 0;
	localparam int AS_ACTIVE_LSB = 1;

	// Reset values
	localparam logic              CC_PULL_RST  = 1'h0;
	localparam logic              CC_CUT_RST   = 1'h0;
	localparam logic              CC_CLKG_RST  = 1'h0;
	localparam logic [FSEL_W-1:0] CC_FSEL_RST  = 2'h0;
	localparam logic [ADDR_W-1:0] AW_ADDR_RST  = 7'h00;
	localparam logic              AW_WAKE_RST  = 1'h0;
	localparam logic [NUM_EP-1:0] STALL_RST    = 4'h0;
	localparam logic              AS_DEFER_RST = 1'h0;
	localparam logic              AS_PEND_RST  = 1'h0;
	localparam logic [DATA_W-1:0] RDATA_RST    = 32'h0000_0000;
endpackage

// file: design/usbsie_sync.sv
`timescale 1ns/10ps
// Three-stage catcher for a level from outside the clock domain
module usbsie_sync (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic async_in,
	output logic      level_out
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} usbsie_sync_s;

	usbsie_sync_s st_ff;
	usbsie_sync_s nxt_st;

	// A change counts only once stages two and three agree
	always_comb begin
		nxt_st     = st_ff;
		nxt_st.s1  = async_in;
		nxt_st.s2  = st_ff.s1;
		nxt_st.s3  = st_ff.s2;
		if (st_ff.s2 == st_ff.s3) begin
			nxt_st.lvl = st_ff.s3;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign level_out = st_ff.lvl;
endmodule

// file: verif/usbsie_host_model.sv
`timescale 1ns/10ps
// Far-side stand-in: token decoder outputs and bus events
module usbsie_host_model
	import usbsie_pkg::*;
(
	input  wire logic         pclk,
	output logic              jstate_line,
	output logic              sie_suspend,
	output logic              usb_bus_reset,
	output logic              setup_token,
	output logic              in_data_read_done,
	output logic              token_valid,
	output logic [ADDR_W-1:0] token_addr,
	output logic [FSEL_W-1:0] token_ep
);
	// Quiet bus at time zero
	initial begin
		{jstate_line, sie_suspend, usb_bus_reset, setup_token, in_data_read_done, token_valid} = '0;
		token_addr = '0;
		token_ep = '0;
	end
	// Line levels; jstate and suspend change together, just after the caller's pclk edge
	task automatic lvl(input logic j, input logic s);
		jstate_line <= j;
		sie_suspend <= s;
	endtask
	task automatic tok_on(input logic [ADDR_W-1:0] a, input logic [FSEL_W-1:0] e);
		token_valid <= 1'b1;
		token_addr <= a;
		token_ep <= e;
	endtask
	// Idle fields inverted so a stale token never matches by luck
	task automatic tok_off();
		token_valid <= 1'b0;
		token_addr <= ~token_addr;
		token_ep <= ~token_ep;
	endtask
	// stall clearing events and the IN data read that drains a deferred address
	// One-cycle event: 0 bus reset, 1 setup token, 2 IN data read
	task automatic pulse(input int k);
		case (k)
			0: usb_bus_reset <= 1'b1;
			1: setup_token <= 1'b1;
			default: in_data_read_done <= 1'b1;
		endcase
		@(posedge pclk);
		{usb_bus_reset, setup_token, in_data_read_done} <= 3'h0;
		@(posedge pclk);
	endtask
endmodule

// file: verif/usbsie_regs_tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module usbsie_regs_tb_top
	import usbsie_pkg::*;
;
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [APB_AW-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [DATA_W-1:0] prdata;
	logic [FSEL_W-1:0] fifo_select, token_ep;
	logic [NUM_EP-1:0] ep_fifo_sel, ep_halt_flags;
	logic [ADDR_W-1:0] device_addr_field, token_addr, a1, a2;
	logic              pready, pslverr, w1, jstate_line, sie_suspend, usb_bus_reset, setup_token;
	logic              in_data_read_done, token_valid, dplus_pull_resistor_en, suspend_current_cut_en;
	logic              usb_clock_gate_en, remote_wake_enable, addr_match, stall_reply;
	logic [32:0]       exp_q[$];
	int                mismatches = 0;
	int                cmp_count = 0;

	initial forever #20 pclk = ~pclk;

	usbsie_regs i_usbsie_regs (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .jstate_line(jstate_line), .sie_suspend(sie_suspend),
		.usb_bus_reset(usb_bus_reset), .setup_token(setup_token), .in_data_read_done(in_data_read_done),
		.token_valid(token_valid), .token_addr(token_addr), .token_ep(token_ep),
		.dplus_pull_resistor_en(dplus_pull_resistor_en), .suspend_current_cut_en(suspend_current_cut_en),
		.usb_clock_gate_en(usb_clock_gate_en), .fifo_select(fifo_select), .ep_fifo_sel(ep_fifo_sel),
		.device_addr_field(device_addr_field), .remote_wake_enable(remote_wake_enable),
		.ep_halt_flags(ep_halt_flags), .addr_match(addr_match), .stall_reply(stall_reply));

	usbsie_host_model i_usbsie_host_model (.pclk(pclk), .jstate_line(jstate_line), .sie_suspend(sie_suspend),
		.usb_bus_reset(usb_bus_reset), .setup_token(setup_token), .in_data_read_done(in_data_read_done),
		.token_valid(token_valid), .token_addr(token_addr), .token_ep(token_ep));

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// APB transfer, entered just after an edge; the expected answer is queued first
	task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [7:0] d, input logic [32:0] e);
		int n;
		exp_q.push_back(e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 16)
			begin mismatches++; tally_and_finish(); end
		@(posedge pclk);
	endtask

	// Token held across one edge; replies are combinational so checked in that cycle
	task automatic tok(input logic [ADDR_W-1:0] a, input logic [FSEL_W-1:0] e, input logic m, input logic s);
		i_usbsie_host_model.tok_on(a, e);
		@(posedge pclk);
		`CHK("addr_match", m, addr_match)
		`CHK("stall_reply", s, stall_reply)
		i_usbsie_host_model.tok_off();
		@(posedge pclk);
	endtask

	// Oldest note is compared whenever a transfer completes
	always @(posedge pclk) begin
		logic [32:0] e;
		if (psel && penable && pready === 1'b1) begin
			e = exp_q.pop_front();
			`CHK("pslverr", e[32], pslverr)
			if (!pwrite)
				`CHK("prdata", e[31:0], prdata)
		end
	end

	initial begin
		void'($urandom(32'hd7f677b9));
		a1 = 7'($urandom);
		a2 = a1 + 7'(1 + $urandom % 100);
		w1 = 1'($urandom);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		`CHK("ep_fifo_sel", 4'h1, ep_fifo_sel)
		`CHK("clock_gate", 1'b0, usb_clock_gate_en)
		apb(0, OFS_CTRL_CONFIG, 0, 33'h0);
		apb(0, OFS_ADDR_WAKE, 0, 33'h0);
		apb(0, OFS_STALL, 0, 33'h0);
		$display("test reset done");
		apb(1, OFS_CTRL_CONFIG, 8'hff, 33'h0);
		apb(0, OFS_CTRL_CONFIG, 0, 33'h9b);
		`CHK("pull", 1'b1, dplus_pull_resistor_en)
		`CHK("clock_gate", 1'b1, usb_clock_gate_en)
		`CHK("cut_en", 1'b0, suspend_current_cut_en)
		for (int i = 0; i < 4; i++) begin
			apb(1, OFS_CTRL_CONFIG, 8'(i), 33'h0);
			`CHK("fifo_select", 2'(i), fifo_select)
			`CHK("ep_fifo_sel", 4'(1 << i), ep_fifo_sel)
		end
		`CHK("pull", 1'b0, dplus_pull_resistor_en)
		apb(1, OFS_CTRL_CONFIG, 8'h10, 33'h0);
		i_usbsie_host_model.lvl(1'b1, 1'b1);
		repeat (6) @(posedge pclk);
		`CHK("cut_en", 1'b1, suspend_current_cut_en)
		apb(0, OFS_CTRL_CONFIG, 0, 33'h30);
		apb(1, OFS_CTRL_CONFIG, 8'h08, 33'h0);
		repeat (2) @(posedge pclk);
		`CHK("cut_en", 1'b0, suspend_current_cut_en)
		i_usbsie_host_model.lvl(1'b0, 1'b0);
		$display("test control done");
		apb(1, OFS_ADDR_WAKE, {a1, w1}, 33'h0);
		@(posedge pclk);
		`CHK("addr", a1, device_addr_field)
		`CHK("wake", w1, remote_wake_enable)
		apb(0, OFS_ADDR_WAKE, 0, {25'h0, a1, w1});
		tok(a1, 2'h0, 1'b1, 1'b0);
		tok(~a1, 2'h0, 1'b0, 1'b0);
		apb(1, OFS_ADDR_STATUS, 8'h01, 33'h0);
		apb(1, OFS_ADDR_WAKE, {a2, 1'b0}, 33'h0);
		repeat (2) @(posedge pclk);
		`CHK("addr", a1, device_addr_field)
		i_usbsie_host_model.pulse(2);
		@(posedge pclk);
		`CHK("addr", a2, device_addr_field)
		apb(0, OFS_ADDR_STATUS, 0, {25'h0, a2, 1'b1});
		apb(1, OFS_ADDR_STATUS, 8'h00, 33'h0);
		$display("test address done");
		apb(1, OFS_STALL, 8'hff, 33'h0);
		apb(0, OFS_STALL, 0, 33'h0f);
		tok(a2, 2'h2, 1'b1, 1'b1);
		apb(1, OFS_STALL, 8'h02, 33'h0);
		tok(a2, 2'h2, 1'b1, 1'b0);
		tok(a2, 2'h1, 1'b1, 1'b1);
		i_usbsie_host_model.pulse(0);
		`CHK("halt", 4'h0, ep_halt_flags)
		apb(1, OFS_STALL, 8'h0f, 33'h0);
		i_usbsie_host_model.pulse(1);
		`CHK("halt", 4'h0, ep_halt_flags)
		apb(1, 8'h10, 8'hff, {1'b1, 32'h0});
		apb(0, 8'h10, 0, {1'b1, 32'h0});
		apb(0, OFS_CTRL_CONFIG, 0, 33'h08);
		$display("test stall done");
		tally_and_finish();
	end
endmodule
